// ==== src/nd_params.svh ====
// Constants of the NAND host sequencer: offsets, fields, commands, timing
`ifndef ND_PARAMS_SVH
`define ND_PARAMS_SVH
// Clock period and strobe times in ns
`define ND_CLK_NS 8
`define ND_TWLO_NS 25
`define ND_TWHI_NS 15
`define ND_TRLO_NS 25
`define ND_TRHI_NS 15
`define ND_TWB_NS 100
// Register byte offsets
`define ND_REG_CTRL 12'h000
`define ND_REG_ROWA 12'h004
`define ND_REG_ROWB 12'h008
`define ND_REG_MOD 12'h00c
`define ND_REG_STAT 12'h010
`define ND_REG_ID0 12'h020
`define ND_REG_ID4 12'h030
// Field positions and reset values
`define ND_CTRL_WP_BIT 8
`define ND_MOD_EN_BIT 31
`define ND_SB_FAIL 0
`define ND_SB_RDY 6
`define ND_WP_RST 1'b0
// Command bytes
`define ND_CMD_READ 8'h00
`define ND_CMD_CBRD 8'h35
`define ND_CMD_ERASE 8'h60
`define ND_CMD_ERGO 8'hd0
`define ND_CMD_CBIN 8'h85
`define ND_CMD_PROG 8'h10
`define ND_CMD_STAT 8'h70
`define ND_CMD_DSTAT 8'h71
`define ND_CMD_ID 8'h90
`define ND_CMD_RST 8'hff
`endif

// ==== src/nd_pkg.sv ====
// Types of the NAND host sequencer
`default_nettype none
package nd_pkg;
  typedef enum logic [2:0] {op_none, op_status, op_id, op_erase2, op_copy,
    op_abort} nd_op_t;
  typedef enum logic [3:0] {k_end, k_cmd, k_addr, k_wdat, k_read, k_busy,
    k_poll, k_skip, k_chk} nd_kind_t;
  typedef struct packed {
    nd_kind_t kind;
    logic [7:0] val;
  } nd_step_t;
  typedef enum logic [2:0] {st_idle, st_fetch, st_drive, st_hold,
    st_wait} nd_st_t;
endpackage
`default_nettype wire

// ==== src/nd_idmem.sv ====
// Small memory holding the identification bytes, registered read
`timescale 1ns/100ps
`default_nettype none
module nd_idmem (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic wr_en, // Write strobe
  input wire logic [2:0] wr_addr, // Write index
  input wire logic [7:0] wr_data, // Write byte
  input wire logic [2:0] rd_addr, // Read index
  output logic [7:0] rd_data // Registered read byte
);
  logic [7:0] mem_ff [8];
  logic [7:0] rd_ff;

  // Array write
  always_ff @(posedge pclk)
  begin
    if (wr_en)
    begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_ff <= 8'h00;
    end
    else
    begin
      rd_ff <= mem_ff[rd_addr];
    end
  end

  assign rd_data = rd_ff;
endmodule
`default_nettype wire

// ==== src/nd_host.sv ====
// NAND host controller: paired erase, copy-back, ID and status over APB
// Function
// - Pair both blocks from the same half
// - Erase at most one block per district
// - Erase: 60 addr, 60 addr, then D0
// - Abort unconfirmed erase with reset FF
// - Check copy-back read result via status
// - Program by 85 with address, 10 confirms
// - Copy source and destination share district
// - Status byte driven on each read strobe
// - Pass/fail valid only once ready
// - Only status or reset while busy
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "nd_params.svh"
module nd_host (
  input wire logic pclk, // Clock, 125 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic chip_enable_n, // Chip enable, active low
  output logic cmd_latch, // Command latch enable
  output logic addr_latch, // Address latch enable
  output logic write_strobe_n, // Write strobe, active low
  output logic read_strobe_n, // Read strobe, active low
  output logic write_protect_n, // Write protect, active low
  output logic [7:0] io_out, // I/O lines, driven value
  output logic io_oe_n, // I/O drive enable, active low
  input wire logic [7:0] io_in, // I/O lines, sampled value
  input wire logic ready_busy_output // Device ready, high when ready
);
  import nd_pkg::*;

  localparam int TWLO = (`ND_TWLO_NS + `ND_CLK_NS - 1) / `ND_CLK_NS;
  localparam int TWHI = (`ND_TWHI_NS + `ND_CLK_NS - 1) / `ND_CLK_NS;
  localparam int TRLO = (`ND_TRLO_NS + `ND_CLK_NS - 1) / `ND_CLK_NS;
  localparam int TRHI = (`ND_TRHI_NS + `ND_CLK_NS - 1) / `ND_CLK_NS;
  localparam int TWB = (`ND_TWB_NS + `ND_CLK_NS - 1) / `ND_CLK_NS;

  // District and half of a row address
  function automatic logic district_f(input logic [17:0] row);
    return row[6];
  endfunction

  function automatic logic half_f(input logic [17:0] row);
    return row[17];
  endfunction

  // Step table of each operation
  function automatic nd_step_t step_f(input nd_op_t op, input logic [4:0] i,
    input logic [17:0] ra, input logic [17:0] rb, input logic [31:0] md);
    nd_step_t s;
    s = '{k_end, 8'h00};
    case (op)
      op_status:
        case (i)
          5'd0: s = '{k_cmd, `ND_CMD_STAT};
          5'd1: s = '{k_read, 8'h00};
          default: s = '{k_end, 8'h00};
        endcase
      op_id:
        if (i == 5'd0) s = '{k_cmd, `ND_CMD_ID};
        else if (i == 5'd1) s = '{k_addr, 8'h00};
        else if (i <= 5'd6) s = '{k_read, 8'h00};
      op_abort:
        case (i)
          5'd0: s = '{k_cmd, `ND_CMD_RST};
          5'd1: s = '{k_busy, 8'h00};
          default: s = '{k_end, 8'h00};
        endcase
      op_erase2:
        case (i)
          5'd0, 5'd4: s = '{k_cmd, `ND_CMD_ERASE};
          5'd1: s = '{k_addr, ra[7:0]};
          5'd2: s = '{k_addr, ra[15:8]};
          5'd3: s = '{k_addr, {6'h00, ra[17:16]}};
          5'd5: s = '{k_addr, rb[7:0]};
          5'd6: s = '{k_addr, rb[15:8]};
          5'd7: s = '{k_addr, {6'h00, rb[17:16]}};
          5'd8: s = '{k_cmd, `ND_CMD_ERGO};
          5'd9: s = '{k_busy, 8'h00};
          5'd10: s = '{k_cmd, `ND_CMD_DSTAT};
          5'd11: s = '{k_read, 8'h00};
          5'd12: s = '{k_poll, 8'h00};
          default: s = '{k_end, 8'h00};
        endcase
      op_copy:
        case (i)
          5'd0: s = '{k_cmd, `ND_CMD_READ};
          5'd1, 5'd2, 5'd12, 5'd13: s = '{k_addr, 8'h00};
          5'd3: s = '{k_addr, ra[7:0]};
          5'd4: s = '{k_addr, ra[15:8]};
          5'd5: s = '{k_addr, {6'h00, ra[17:16]}};
          5'd6: s = '{k_cmd, `ND_CMD_CBRD};
          5'd7, 5'd23: s = '{k_busy, 8'h00};
          5'd8, 5'd24: s = '{k_cmd, `ND_CMD_STAT};
          5'd9, 5'd25: s = '{k_read, 8'h00};
          5'd10: s = '{k_chk, 8'h00};
          5'd11, 5'd18: s = '{k_cmd, `ND_CMD_CBIN};
          5'd14: s = '{k_addr, rb[7:0]};
          5'd15: s = '{k_addr, rb[15:8]};
          5'd16: s = '{k_addr, {6'h00, rb[17:16]}};
          5'd17: s = '{k_skip, 8'd22};
          5'd19: s = '{k_addr, md[23:16]};
          5'd20: s = '{k_addr, {3'h0, md[28:24]}};
          5'd21: s = '{k_wdat, md[7:0]};
          5'd22: s = '{k_cmd, `ND_CMD_PROG};
          5'd26: s = '{k_poll, 8'h00};
          default: s = '{k_end, 8'h00};
        endcase
      default: s = '{k_end, 8'h00};
    endcase
    return s;
  endfunction

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic wp_ff;
  logic [17:0] rowa_ff;
  logic [17:0] rowb_ff;
  logic [31:0] mod_ff;
  logic done_ff;
  logic rerr_ff;
  logic cfail_ff;
  logic [7:0] stat_ff;
  nd_st_t st_ff;
  nd_op_t op_ff;
  logic [4:0] idx_ff;
  logic [4:0] tmr_ff;
  logic ce_n_ff;
  logic cle_ff;
  logic ale_ff;
  logic we_n_ff;
  logic rdstb_n_ff;
  logic [7:0] iod_ff;
  logic oe_n_ff;
  logic id_we;
  logic [7:0] id_rd;
  logic acc_w;
  logic acc_r;
  logic wr_ctrl;
  nd_op_t new_op;
  logic rule_ok;
  logic start;
  logic reject;
  nd_step_t step;
  logic ev_end;
  logic ev_cfail;
  logic [31:0] rd_mux;
  logic hit;

  // APB access phases
  assign acc_r = psel && penable && !pready_ff;
  assign acc_w = psel && penable && pready_ff && pwrite;
  assign wr_ctrl = acc_w && (paddr == `ND_REG_CTRL);
  assign new_op = nd_op_t'(pwdata[2:0]);

  // Pairing checks on the stored rows
  always_comb
  begin
    rule_ok = 1'b1;
    if (new_op == op_erase2)
    begin
      rule_ok = (district_f(rowa_ff) != district_f(rowb_ff)) &&
        (half_f(rowa_ff) == half_f(rowb_ff));
    end
    else if (new_op == op_copy)
    begin
      rule_ok = district_f(rowa_ff) == district_f(rowb_ff);
    end
  end

  assign start = wr_ctrl && (new_op != op_none) && (st_ff == st_idle) &&
    rule_ok;
  assign reject = wr_ctrl && (new_op != op_none) && !rule_ok;
  assign step = step_f(op_ff, idx_ff, rowa_ff, rowb_ff, mod_ff);
  assign ev_cfail = (st_ff == st_fetch) && (step.kind == k_chk) &&
    stat_ff[`ND_SB_FAIL];
  assign ev_end = ((st_ff == st_fetch) && (step.kind == k_end)) || ev_cfail;
  assign id_we = (st_ff == st_drive) && (tmr_ff == 5'd0) && !rdstb_n_ff &&
    (op_ff == op_id);

  // Read decode
  always_comb
  begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == `ND_REG_CTRL)
      rd_mux = {23'h0, wp_ff, 5'h00, op_ff};
    else if (paddr == `ND_REG_ROWA)
      rd_mux = {14'h0, rowa_ff};
    else if (paddr == `ND_REG_ROWB)
      rd_mux = {14'h0, rowb_ff};
    else if (paddr == `ND_REG_MOD)
      rd_mux = mod_ff;
    else if (paddr == `ND_REG_STAT)
      rd_mux = {16'h0, stat_ff, 4'h0, cfail_ff, rerr_ff, done_ff,
        st_ff != st_idle};
    else if (paddr >= `ND_REG_ID0 && paddr <= `ND_REG_ID4 &&
      paddr[1:0] == 2'b00)
      rd_mux = {24'h0, id_rd};
    else
      hit = 1'b0;
  end

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= acc_r;
      if (acc_r)
      begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_ff <= !hit;
      end
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_ff <= `ND_WP_RST;
      rowa_ff <= 18'h00000;
      rowb_ff <= 18'h00000;
      mod_ff <= 32'h0000_0000;
    end
    else if (acc_w)
    begin
      if (paddr == `ND_REG_CTRL)
        wp_ff <= pwdata[`ND_CTRL_WP_BIT];
      else if (paddr == `ND_REG_ROWA)
        rowa_ff <= pwdata[17:0];
      else if (paddr == `ND_REG_ROWB)
        rowb_ff <= pwdata[17:0];
      else if (paddr == `ND_REG_MOD)
        mod_ff <= pwdata;
    end
  end

  // Sticky flags, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_ff <= 1'b0;
      rerr_ff <= 1'b0;
      cfail_ff <= 1'b0;
    end
    else
    begin
      done_ff <= ev_end || (done_ff && !(acc_w &&
        paddr == `ND_REG_STAT && pwdata[1]));
      rerr_ff <= reject || (rerr_ff && !(acc_w &&
        paddr == `ND_REG_STAT && pwdata[2]));
      cfail_ff <= ev_cfail || (cfail_ff && !(acc_w &&
        paddr == `ND_REG_STAT && pwdata[3]));
    end
  end

  // Step sequencer and pin drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= st_idle;
      op_ff <= op_none;
      idx_ff <= 5'd0;
      tmr_ff <= 5'd0;
      ce_n_ff <= 1'b1;
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
      we_n_ff <= 1'b1;
      rdstb_n_ff <= 1'b1;
      iod_ff <= 8'h00;
      oe_n_ff <= 1'b1;
      stat_ff <= 8'h00;
    end
    else
    begin
      case (st_ff)
        st_idle:
          if (start)
          begin
            op_ff <= new_op;
            idx_ff <= 5'd0;
            ce_n_ff <= 1'b0;
            st_ff <= st_fetch;
          end
        st_fetch:
          case (step.kind)
            k_cmd, k_addr, k_wdat:
            begin
              cle_ff <= step.kind == k_cmd;
              ale_ff <= step.kind == k_addr;
              iod_ff <= step.val;
              oe_n_ff <= 1'b0;
              we_n_ff <= 1'b0;
              tmr_ff <= 5'(TWLO - 1);
              st_ff <= st_drive;
            end
            k_read:
            begin
              oe_n_ff <= 1'b1;
              rdstb_n_ff <= 1'b0;
              tmr_ff <= 5'(TRLO - 1);
              st_ff <= st_drive;
            end
            k_busy:
            begin
              oe_n_ff <= 1'b1;
              tmr_ff <= 5'(TWB - 1);
              st_ff <= st_wait;
            end
            k_poll:
              idx_ff <= stat_ff[`ND_SB_RDY] ? idx_ff + 5'd1 : idx_ff - 5'd1;
            k_skip:
              idx_ff <= mod_ff[`ND_MOD_EN_BIT] ? idx_ff + 5'd1 : step.val[4:0];
            k_chk:
              if (stat_ff[`ND_SB_FAIL])
              begin
                ce_n_ff <= 1'b1;
                st_ff <= st_idle;
              end
              else
                idx_ff <= idx_ff + 5'd1;
            default:
            begin
              ce_n_ff <= 1'b1;
              oe_n_ff <= 1'b1;
              st_ff <= st_idle;
            end
          endcase
        st_drive:
          if (tmr_ff != 5'd0)
            tmr_ff <= tmr_ff - 5'd1;
          else
          begin
            if (!rdstb_n_ff && op_ff != op_id)
              stat_ff <= io_in;
            we_n_ff <= 1'b1;
            rdstb_n_ff <= 1'b1;
            tmr_ff <= rdstb_n_ff ? 5'(TWHI - 1) : 5'(TRHI - 1);
            st_ff <= st_hold;
          end
        st_hold:
          if (tmr_ff != 5'd0)
            tmr_ff <= tmr_ff - 5'd1;
          else
          begin
            cle_ff <= 1'b0;
            ale_ff <= 1'b0;
            idx_ff <= idx_ff + 5'd1;
            st_ff <= st_fetch;
          end
        st_wait:
          if (tmr_ff != 5'd0)
            tmr_ff <= tmr_ff - 5'd1;
          else if (ready_busy_output)
          begin
            idx_ff <= idx_ff + 5'd1;
            st_ff <= st_fetch;
          end
        default: st_ff <= st_idle;
      endcase
    end
  end

  nd_idmem u_idmem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(id_we),
    .wr_addr(3'(idx_ff - 5'd2)),
    .wr_data(io_in),
    .rd_addr(paddr[4:2]),
    .rd_data(id_rd)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign chip_enable_n = ce_n_ff;
  assign cmd_latch = cle_ff;
  assign addr_latch = ale_ff;
  assign write_strobe_n = we_n_ff;
  assign read_strobe_n = rdstb_n_ff;
  assign write_protect_n = wp_ff;
  assign io_out = iod_ff;
  assign io_oe_n = oe_n_ff;

  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  erase_district_a: assert property (
    $rose(st_ff == st_fetch) && op_ff == op_erase2 |->
      rowa_ff[6] != rowb_ff[6]) else $error("erase pair same district");
  erase_half_a: assert property (
    $rose(st_ff == st_fetch) && op_ff == op_erase2 |->
      rowa_ff[17] == rowb_ff[17]) else $error("erase pair split halves");
  copy_district_a: assert property (
    $rose(st_ff == st_fetch) && op_ff == op_copy |->
      rowa_ff[6] == rowb_ff[6]) else $error("copy across districts");
  abort_first_a: assert property (
    $rose(st_ff == st_fetch) && idx_ff == 5'd0 && op_ff == op_abort |=>
      cmd_latch && io_out == 8'hff && !write_strobe_n)
    else $error("abort did not send reset");
  strobe_width_a: assert property (
    $fell(write_strobe_n) |-> (!write_strobe_n && !io_oe_n)[*4]
      ##1 write_strobe_n) else $error("write strobe width wrong");
  busy_quiet_a: assert property (
    st_ff == st_wait |-> write_strobe_n && read_strobe_n && io_oe_n)
    else $error("strobe while waiting on busy");
  read_release_a: assert property (
    !read_strobe_n |-> io_oe_n && !cmd_latch && !addr_latch)
    else $error("read strobe while driving");
  ready_result_a: assert property (
    ev_end && !ev_cfail && (op_ff == op_erase2 || op_ff == op_copy) |->
      stat_ff[6]) else $error("result taken while busy");
  copy_confirm_a: assert property (
    $fell(write_strobe_n) && io_out == 8'h10 && cmd_latch |->
      op_ff == op_copy && idx_ff == 5'd22) else $error("stray confirm");
endmodule
`default_nettype wire

// ==== tb/nd_dev_model.sv ====
// Behavioural NAND device facing the host sequencer
`timescale 1ns/100ps
`default_nettype none
module nd_dev_model #(
  parameter int BUSY_NS = 400, // Array busy time in ns
  parameter logic [7:0] ID1 = 8'h5a, // Maker code, arbitrary
  parameter logic [7:0] ID2 = 8'ha7 // Device code, arbitrary
) (
  input wire logic chip_enable_n, // Chip enable
  input wire logic cmd_latch, // Command cycle
  input wire logic addr_latch, // Address cycle
  input wire logic write_strobe_n, // Write strobe
  input wire logic read_strobe_n, // Read strobe
  input wire logic write_protect_n, // Write protect
  input wire logic [7:0] io_out, // Byte on the wire
  input wire logic [1:0] fail_d, // Failing districts
  output logic [7:0] io_in, // Byte offered
  output logic busy // Array busy
);
  // ********************************************************
  // Command decoding and read data
  // ********************************************************
  logic [7:0] mode, last, rd, dat_last;
  logic [63:0] cmd_hist, adr_hist;
  logic [2:0] idx;
  event go;
  initial
  begin
    mode = 8'h00;
    last = 8'h00;
    dat_last = 8'h00;
    cmd_hist = 64'h0;
    adr_hist = 64'h0;
    idx = 3'd0;
    busy = 1'b0;
  end
  // Bytes are taken on the rising write strobe
  always @(posedge write_strobe_n)
  begin
    if (!chip_enable_n && cmd_latch)
    begin
      cmd_hist = {cmd_hist[55:0], io_out};
      mode = io_out;
      idx = 3'd0;
      if (io_out inside {8'hd0, 8'h10, 8'h35, 8'hff})
        -> go;
    end
    else if (!chip_enable_n && addr_latch)
      adr_hist = {adr_hist[55:0], io_out};
    else if (!chip_enable_n)
      dat_last = io_out;
  end
  // Busy window of an array operation
  always
  begin
    @(go);
    busy = 1'b1;
    #(BUSY_NS);
    busy = 1'b0;
  end
  // Byte for the current read strobe
  always @*
  begin
    case (mode)
      8'h70:
        rd = {write_protect_n, ~busy, ~busy, 4'h0, |fail_d};
      8'h71:
        rd = {write_protect_n, ~busy, ~busy, 2'b00, fail_d, |fail_d};
      8'h90: rd = (idx == 3'd0) ? ID1 : (idx == 3'd1) ? ID2 :
        (idx == 3'd2) ? 8'h95 :
        (idx == 3'd3) ? 8'h25 : 8'hfa;
      default: rd = 8'h00;
    endcase
  end
  // Released lines show the inverse of the last byte
  assign io_in = (!chip_enable_n && !read_strobe_n) ? rd : ~last;
  always @(posedge read_strobe_n)
  begin
    last = rd;
    if (mode == 8'h90)
      idx = idx + 3'd1;
  end
endmodule
`default_nettype wire

// ==== tb/nd_host_tb_top.sv ====
// Self-checking bench of the NAND host sequencer
`timescale 1ns/100ps
`default_nettype none
`include "nd_params.svh"
`define CHK(nm, e, s) \
  begin \
    check_count++; \
    if ((s) !== (e)) \
    begin \
      fail_count++; \
      $display("ERROR %s expected %h seen %h", nm, e, s); \
    end \
  end
module nd_host_tb_top;
  // ********************************************************
  // Bench signals, partner and tasks
  // ********************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, er, wp;
  logic chip_enable_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n;
  logic write_protect_n, io_oe_n, ready_busy_output;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, st;
  logic [7:0] io_out, dev_io, io_bus;
  logic [1:0] fail_d;
  logic [63:0] h;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  // Wire levels: pulled-up busy line, shared I/O
  assign ready_busy_output = busy ? 1'b0 : 1'b1;
  assign io_bus = !io_oe_n ? io_out : dev_io;
  nd_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n),
    .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_bus),
    .ready_busy_output(ready_busy_output));
  nd_dev_model i_dev (.chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n),
    .io_out(io_bus), .fail_d(fail_d), .io_in(dev_io), .busy(busy));
  // Clock and hang guard
  always #4 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer, result left in rv and er; an idle edge follows
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Start an operation, wait for done or reject, clear sticky bits
  task automatic run_op(input logic [2:0] op);
    int n;
    n = 0;
    apb(1'b1, `ND_REG_CTRL, {23'h0, wp, 5'h0, op});
    do
    begin
      apb(1'b0, `ND_REG_STAT, 32'h0);
      n++;
    end
    while (rv[2:1] === 2'b00 && n < 500);
    st = rv;
    `CHK("finished", 1'b1, |st[2:1]);
    apb(1'b1, `ND_REG_STAT, 32'he);
  endtask
  task automatic t_status;
    for (int i = 0; i < 2; i++)
    begin
      wp = i[0];
      run_op(3'd1);
      `CHK("wp pin", wp, write_protect_n);
      `CHK("status", {wp, 7'h60}, st[15:8]);
      `CHK("cmd", 8'h70, i_dev.cmd_hist[7:0]);
    end
  endtask
  task automatic t_id;
    // Bytes 3 to 5: two chips, four levels; 2 KB, 256 KB, x8; 4 planes, ECC
    logic [7:0] e [5] = '{8'h5a, 8'ha7, 8'h95, 8'h25, 8'hfa};
    run_op(3'd2);
    `CHK("id", 16'h9000, {i_dev.cmd_hist[7:0], i_dev.adr_hist[7:0]});
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, `ND_REG_ID0 + 12'(4 * i), 32'h0);
      `CHK("id byte", e[i], rv[7:0]);
    end
  endtask
  task automatic t_erase;
    logic [11:0] ba [4] = '{12'd2049, 12'd4, 12'd2, 12'd2};
    logic [11:0] bb [4] = '{12'd4094, 12'd1, 12'd4, 12'd2049};
    logic [17:0] ra, rb;
    logic [47:0] ea;
    fail_d <= 2'b10;
    for (int i = 0; i < 4; i++)
    begin
      ra = {ba[i], 6'd5};
      rb = {bb[i], 6'd0};
      ea = {ra[7:0], ra[15:8], 6'h0, ra[17:16], rb[7:0], rb[15:8], 6'h0,
        rb[17:16]};
      h = i_dev.cmd_hist;
      apb(1'b1, `ND_REG_ROWA, {14'h0, ra});
      apb(1'b1, `ND_REG_ROWB, {14'h0, rb});
      run_op(3'd3);
      if (i < 2)
      begin
        `CHK("erase cmds", 32'h6060d071, i_dev.cmd_hist[31:0]);
        `CHK("erase rows", ea, i_dev.adr_hist[47:0]);
        `CHK("district status", 8'he5, st[15:8]);
      end
      else
        `CHK("no cmds", h, i_dev.cmd_hist);
      `CHK("reject", i >= 2, st[2]);
    end
    fail_d <= 2'b00;
  endtask
  task automatic t_copy;
    apb(1'b1, `ND_REG_ROWA, {14'h0, 12'd4, 6'd3});
    apb(1'b1, `ND_REG_ROWB, {14'h0, 12'd6, 6'd1});
    apb(1'b1, `ND_REG_MOD, 32'h0);
    fail_d <= 2'b01;
    run_op(3'd4);
    `CHK("read fail", 1'b1, st[3]);
    `CHK("stop", 24'h003570, i_dev.cmd_hist[23:0]);
    fail_d <= 2'b00;
    apb(1'b1, `ND_REG_MOD, {1'b1, 2'b00, 13'h123, 8'h00, 8'ha5});
    run_op(3'd4);
    `CHK("cmds", 56'h00357085851070, i_dev.cmd_hist[55:0]);
    `CHK("column", 16'h2301, i_dev.adr_hist[15:0]);
    `CHK("new byte", 8'ha5, i_dev.dat_last);
    `CHK("copy status", 8'he0, st[15:8]);
    `CHK("copy flags", 2'b00, st[3:2]);
    apb(1'b1, `ND_REG_ROWB, {14'h0, 12'd7, 6'd1});
    h = i_dev.cmd_hist;
    run_op(3'd4);
    `CHK("cross district", 1'b1, st[2]);
    `CHK("no cmds", h, i_dev.cmd_hist);
  endtask
  // Main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_d = 2'b00;
    wp = 1'b1;
    repeat (5) @(posedge pclk);
    `CHK("ce idle", 1'b1, chip_enable_n);
    `CHK("wp reset", 1'b0, write_protect_n);
    `CHK("oe idle", 1'b1, io_oe_n);
    presetn <= 1'b1;
    apb(1'b0, 12'h100, 32'h0);
    `CHK("unmapped", 1'b1, er);
    t_status;
    t_id;
    t_erase;
    t_copy;
    run_op(3'd5);
    `CHK("abort", 8'hff, i_dev.cmd_hist[7:0]);
    end_sim;
  end
endmodule
`default_nettype wire
